// ---- common/rpv_pkg.sv ----
package rpv_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_RX_POWER_DOWN = 16'h2001;
    localparam logic [15:0] ADDR_VALIDATE_NOW = 16'h2002;
    localparam logic [15:0] ADDR_FORCE_INVALID = 16'h2003;
    localparam logic [15:0] ADDR_MONITOR_SKIP = 16'h2004;
    localparam logic [15:0] ADDR_UPDATE = 16'h000f;
    localparam logic [7:0] UPDATE_CODE = 8'h01;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ------------------------------------------------------------
    // Field layout: one bit per reference input
    // ------------------------------------------------------------
    localparam int NUM_INPUTS = 4;
    localparam int BIT_INPUT_A = 0;
    localparam int BIT_INPUT_AA = 1;
    localparam int BIT_INPUT_B = 2;
    localparam int BIT_INPUT_BB = 3;
    localparam logic [3:0] INPUTS_RESET = 4'h0;

    typedef logic [3:0] rpv_inputs_t;

    // ------------------------------------------------------------
    // Register access request from the serial control port
    // ------------------------------------------------------------
    typedef struct packed {
        logic write;
        logic read;
        logic [15:0] addr;
        logic [7:0] wdata;
    } rpv_reg_req_s;

endpackage : rpv_pkg

// ---- src/rpv_ref_input_ctrl.sv ----
// Operation
// - Power-down bit 2 turns off input b receiver.
// - Power-down bit 1 turns off input aa receiver.
// - Power-down bit 0 turns off input a receiver.
// - Override bit 3 validates unfaulted counting input bb.
// - Override bit 2 validates unfaulted counting input b.
// - Override bit 1 validates unfaulted counting input aa.
// - Override bits clear themselves after acting.
// - Override ignored when faulted or timer idle.
// - Monitor skip treats the input as unfaulted.
// - Force invalid keeps the input unavailable always.
`timescale 1ns/10ps
`default_nettype none

module rpv_ref_input_ctrl
(
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RST_IN,
    // Register access from the serial control port
    input wire rpv_pkg::rpv_reg_req_s REQ_IN,
    output logic [7:0] RDATA_OUT,
    output logic RDATA_VALID_OUT,
    // Reference monitors and validation timers
    input wire rpv_pkg::rpv_inputs_t MONITOR_FAULT_IN,
    input wire rpv_pkg::rpv_inputs_t TIMER_RUNNING_IN,
    input wire rpv_pkg::rpv_inputs_t TIMER_EXPIRED_IN,
    // Receiver and validation state
    output rpv_pkg::rpv_inputs_t RX_OFF_OUT,
    output rpv_pkg::rpv_inputs_t UNFAULTED_OUT,
    output rpv_pkg::rpv_inputs_t VALID_OUT,
    output rpv_pkg::rpv_inputs_t VALIDATE_NOW_OUT
);

    // ------------------------------------------------------------
    // Staged and active register copies
    // ------------------------------------------------------------
    // Writes land in the staged copy; an update moves them to the active
    // copy so that several bits can be changed together without glitches.
    rpv_pkg::rpv_inputs_t stage_rx_off;
    rpv_pkg::rpv_inputs_t stage_validate_now;
    rpv_pkg::rpv_inputs_t stage_force_invalid;
    rpv_pkg::rpv_inputs_t stage_monitor_skip;
    rpv_pkg::rpv_inputs_t active_force_invalid;
    rpv_pkg::rpv_inputs_t active_monitor_skip;
    rpv_pkg::rpv_inputs_t unfaulted;
    rpv_pkg::rpv_inputs_t next_override;
    logic update;

    function automatic logic hit(input rpv_pkg::rpv_reg_req_s req, input logic [15:0] addr);
        hit = req.write && (req.addr == addr);
    endfunction : hit

    // The reserved upper bits of every register are dropped on a write and
    // read back as zero, so only the four per-input bits are stored.
    function automatic rpv_pkg::rpv_inputs_t low_field(input logic [7:0] data);
        low_field = data[3:0];
    endfunction : low_field

    function automatic logic [7:0] read_word(input rpv_pkg::rpv_inputs_t bits);
        read_word = {4'h0, bits};
    endfunction : read_word

    assign update = hit(REQ_IN, rpv_pkg::ADDR_UPDATE) && (REQ_IN.wdata == rpv_pkg::UPDATE_CODE);

    // Unfaulted view uses the active settings, so the update that applies a
    // skip bit is seen by an override issued on a later update only.
    always_comb
    begin
        for (int i = 0; i < rpv_pkg::NUM_INPUTS; i++)
        begin
            unfaulted[i] = active_monitor_skip[i] || !MONITOR_FAULT_IN[i];
        end
        next_override = stage_validate_now & unfaulted & TIMER_RUNNING_IN & ~active_force_invalid;
    end

    // ------------------------------------------------------------
    // Staged writes
    // ------------------------------------------------------------
    // Each staged register has its own process, so a write to a staged address
    // touches only that register; an update write also clears the override request.
    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            stage_rx_off <= rpv_pkg::INPUTS_RESET;
        end
        else if (hit(REQ_IN, rpv_pkg::ADDR_RX_POWER_DOWN))
        begin
            stage_rx_off <= low_field(REQ_IN.wdata);
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            stage_force_invalid <= rpv_pkg::INPUTS_RESET;
        end
        else if (hit(REQ_IN, rpv_pkg::ADDR_FORCE_INVALID))
        begin
            stage_force_invalid <= low_field(REQ_IN.wdata);
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            stage_monitor_skip <= rpv_pkg::INPUTS_RESET;
        end
        else if (hit(REQ_IN, rpv_pkg::ADDR_MONITOR_SKIP))
        begin
            stage_monitor_skip <= low_field(REQ_IN.wdata);
        end
    end

    // The override request is dropped by every update, acted on or not, so a
    // stale request can never fire on some later update.
    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            stage_validate_now <= rpv_pkg::INPUTS_RESET;
        end
        else if (hit(REQ_IN, rpv_pkg::ADDR_VALIDATE_NOW))
        begin
            stage_validate_now <= low_field(REQ_IN.wdata);
        end
        else if (update)
        begin
            stage_validate_now <= rpv_pkg::INPUTS_RESET;
        end
    end

    // ------------------------------------------------------------
    // Active settings, applied on update
    // ------------------------------------------------------------
    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            RX_OFF_OUT <= rpv_pkg::INPUTS_RESET;
        end
        else if (update)
        begin
            RX_OFF_OUT[rpv_pkg::BIT_INPUT_A] <= stage_rx_off[rpv_pkg::BIT_INPUT_A];
            RX_OFF_OUT[rpv_pkg::BIT_INPUT_AA] <= stage_rx_off[rpv_pkg::BIT_INPUT_AA];
            RX_OFF_OUT[rpv_pkg::BIT_INPUT_B] <= stage_rx_off[rpv_pkg::BIT_INPUT_B];
            RX_OFF_OUT[rpv_pkg::BIT_INPUT_BB] <= stage_rx_off[rpv_pkg::BIT_INPUT_BB];
        end
    end

    // Skip and force bits move together, so software can swap one for the
    // other in a single update without a cycle in which neither holds.
    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            active_force_invalid <= rpv_pkg::INPUTS_RESET;
            active_monitor_skip <= rpv_pkg::INPUTS_RESET;
        end
        else if (update)
        begin
            active_force_invalid <= stage_force_invalid;
            active_monitor_skip <= stage_monitor_skip;
        end
    end

    // ------------------------------------------------------------
    // Validation state
    // ------------------------------------------------------------
    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            VALIDATE_NOW_OUT <= rpv_pkg::INPUTS_RESET;
            VALID_OUT <= rpv_pkg::INPUTS_RESET;
            UNFAULTED_OUT <= rpv_pkg::INPUTS_RESET;
        end
        else
        begin
            UNFAULTED_OUT <= unfaulted;
            VALIDATE_NOW_OUT <= update ? next_override : rpv_pkg::INPUTS_RESET;
            for (int i = 0; i < rpv_pkg::NUM_INPUTS; i++)
            begin
                if (active_force_invalid[i] || !unfaulted[i])
                begin
                    VALID_OUT[i] <= 1'b0;
                end
                else if (TIMER_EXPIRED_IN[i] || (update && next_override[i]))
                begin
                    VALID_OUT[i] <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------
    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            RDATA_OUT <= rpv_pkg::RESET_VALUE;
            RDATA_VALID_OUT <= 1'b0;
        end
        else
        begin
            RDATA_VALID_OUT <= REQ_IN.read;
            if (REQ_IN.read)
            begin
                unique case (REQ_IN.addr)
                    rpv_pkg::ADDR_RX_POWER_DOWN: RDATA_OUT <= read_word(stage_rx_off);
                    rpv_pkg::ADDR_VALIDATE_NOW: RDATA_OUT <= read_word(stage_validate_now);
                    rpv_pkg::ADDR_FORCE_INVALID: RDATA_OUT <= read_word(stage_force_invalid);
                    rpv_pkg::ADDR_MONITOR_SKIP: RDATA_OUT <= read_word(stage_monitor_skip);
                    default: RDATA_OUT <= rpv_pkg::UNMAPPED_READ;
                endcase
            end
        end
    end

endmodule : rpv_ref_input_ctrl
`default_nettype wire

// ---- testbench/rpv_ref_input_ctrl_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module rpv_ref_input_ctrl_chk
(
    // Clock, reset and register access
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire rpv_pkg::rpv_reg_req_s REQ_IN,
    input wire logic RDATA_VALID_OUT,
    // Reference state
    input wire rpv_pkg::rpv_inputs_t MONITOR_FAULT_IN,
    input wire rpv_pkg::rpv_inputs_t TIMER_RUNNING_IN,
    input wire rpv_pkg::rpv_inputs_t RX_OFF_OUT,
    input wire rpv_pkg::rpv_inputs_t UNFAULTED_OUT,
    input wire rpv_pkg::rpv_inputs_t VALID_OUT,
    input wire rpv_pkg::rpv_inputs_t VALIDATE_NOW_OUT
);
    logic upd;
    assign upd = REQ_IN.write && REQ_IN.addr == rpv_pkg::ADDR_UPDATE && REQ_IN.wdata == rpv_pkg::UPDATE_CODE;
    default clocking dcb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    sequence override_s;
        upd ##1 (VALIDATE_NOW_OUT != 4'h0);
    endsequence
    rst_zero_a: assert property ($past(RST_IN) |-> {RX_OFF_OUT, VALID_OUT, VALIDATE_NOW_OUT} == 12'h000)
        else $error("outputs not cleared by reset");
    rx_hold_a: assert property (!upd |=> $stable(RX_OFF_OUT))
        else $error("receiver power-down changed without update");
    rd_valid_a: assert property (RDATA_VALID_OUT == $past(REQ_IN.read))
        else $error("read answer not one cycle after request");
    now_pulse_a: assert property (override_s |=> VALIDATE_NOW_OUT == 4'h0)
        else $error("override pulse longer than one cycle");
    now_valid_a: assert property ((VALIDATE_NOW_OUT & ~VALID_OUT) == 4'h0)
        else $error("override acted but input not valid");
    now_cause_a: assert property (VALIDATE_NOW_OUT != 4'h0 |-> $past(upd))
        else $error("override acted without update");
    now_guard_a: assert property ((VALIDATE_NOW_OUT & ~$past(TIMER_RUNNING_IN)) == 4'h0)
        else $error("override acted with timer idle");
    unf_track_a: assert property (!$past(RST_IN) |-> (~$past(MONITOR_FAULT_IN) & ~UNFAULTED_OUT) == 4'h0)
        else $error("fault-free input not reported unfaulted");
endmodule : rpv_ref_input_ctrl_chk
bind rpv_ref_input_ctrl rpv_ref_input_ctrl_chk chk (.CLK_IN, .RST_IN, .REQ_IN, .RDATA_VALID_OUT, .MONITOR_FAULT_IN,
    .TIMER_RUNNING_IN, .RX_OFF_OUT, .UNFAULTED_OUT, .VALID_OUT, .VALIDATE_NOW_OUT);
`default_nettype wire

// ---- testbench/rpv_ref_input_ctrl_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module rpv_ref_input_ctrl_tb;
    logic CLK_IN = 1'b0;
    logic RST_IN = 1'b1;
    rpv_pkg::rpv_reg_req_s req = '0;
    rpv_pkg::rpv_inputs_t fault = 4'hf;
    rpv_pkg::rpv_inputs_t running = 4'h0;
    rpv_pkg::rpv_inputs_t expired = 4'h0;
    rpv_pkg::rpv_inputs_t rx_off, unf, valid, now_p;
    logic [7:0] rdata;
    logic rvalid;
    int fail_count = 0;
    int num_checks = 0;
    logic [7:0] seed = 8'h02;
    logic [3:0] acc = 4'h0;
    rpv_ref_input_ctrl dut (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .REQ_IN(req), .RDATA_OUT(rdata), .RDATA_VALID_OUT(rvalid),
        .MONITOR_FAULT_IN(fault), .TIMER_RUNNING_IN(running), .TIMER_EXPIRED_IN(expired), .RX_OFF_OUT(rx_off),
        .UNFAULTED_OUT(unf), .VALID_OUT(valid), .VALIDATE_NOW_OUT(now_p));
    initial forever #50 CLK_IN = ~CLK_IN;
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    function automatic rpv_pkg::rpv_inputs_t exp_unf(input rpv_pkg::rpv_inputs_t skip, input rpv_pkg::rpv_inputs_t flt);
        return skip | ~flt;
    endfunction : exp_unf
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        num_checks++;
        if (s !== e)
        begin
            $display("BAD %s expected %h seen %h", n, e, s);
            fail_count++;
        end
    endtask : chk
    // Requests are one-cycle pulses, so each access is followed by an idle cycle.
    task automatic op(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
        @(negedge CLK_IN);
        req = {w, r, a, d};
        @(negedge CLK_IN);
        req = '0;
    endtask : op
    task automatic upd();
        op(1'b1, 1'b0, rpv_pkg::ADDR_UPDATE, rpv_pkg::UPDATE_CODE);
    endtask : upd
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        op(1'b0, 1'b1, a, 8'h00);
        chk("read valid", 8'h01, {7'h00, rvalid});
        chk("read data", e, rdata);
    endtask : rd
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict
    initial
    begin
        repeat (4) @(posedge CLK_IN);
        @(negedge CLK_IN);
        RST_IN = 1'b0;
        chk("reset outputs", 8'h00, {rx_off, valid});
        rd(rpv_pkg::ADDR_RX_POWER_DOWN, 8'h00);
        rd(rpv_pkg::ADDR_VALIDATE_NOW, 8'h00);
        rd(16'h2005, rpv_pkg::UNMAPPED_READ);
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            op(1'b1, 1'b0, rpv_pkg::ADDR_RX_POWER_DOWN, seed);
            rd(rpv_pkg::ADDR_RX_POWER_DOWN, {4'h0, seed[3:0]});
            op(1'b1, 1'b0, rpv_pkg::ADDR_UPDATE, 8'h03);
            chk("rx off held", {4'h0, acc}, {4'h0, rx_off});
            upd();
            acc = seed[3:0];
            chk("rx off", {4'h0, acc}, {4'h0, rx_off});
        end
        op(1'b1, 1'b0, rpv_pkg::ADDR_MONITOR_SKIP, 8'h06);
        op(1'b1, 1'b0, rpv_pkg::ADDR_FORCE_INVALID, 8'h04);
        upd();
        running = 4'hd;
        op(1'b1, 1'b0, rpv_pkg::ADDR_VALIDATE_NOW, 8'h0e);
        upd();
        chk("blocked override", 8'h00, {now_p, valid});
        chk("unfaulted", {4'h0, exp_unf(4'h6, fault)}, {4'h0, unf});
        rd(rpv_pkg::ADDR_VALIDATE_NOW, 8'h00);
        op(1'b1, 1'b0, rpv_pkg::ADDR_MONITOR_SKIP, 8'h0f);
        op(1'b1, 1'b0, rpv_pkg::ADDR_FORCE_INVALID, 8'h00);
        upd();
        running = 4'hf;
        acc = 4'h0;
        for (int i = 0; i < 4; i++)
        begin
            acc[i] = 1'b1;
            op(1'b1, 1'b0, rpv_pkg::ADDR_VALIDATE_NOW, 8'h01 << i);
            upd();
            chk("override", {4'h1 << i, acc}, {now_p, valid});
        end
        rd(rpv_pkg::ADDR_VALIDATE_NOW, 8'h00);
        expired = 4'hf;
        op(1'b1, 1'b0, rpv_pkg::ADDR_FORCE_INVALID, 8'h0f);
        upd();
        op(1'b0, 1'b0, 16'h0000, 8'h00);
        chk("forced invalid", 8'h00, {4'h0, valid});
        op(1'b1, 1'b0, rpv_pkg::ADDR_MONITOR_SKIP, 8'h00);
        op(1'b1, 1'b0, rpv_pkg::ADDR_FORCE_INVALID, 8'h00);
        upd();
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            fault = seed[7:4];
            op(1'b0, 1'b0, 16'h0000, 8'h00);
            chk("unfaulted", {4'h0, exp_unf(4'h0, fault)}, {4'h0, unf});
            chk("expired valid", {4'h0, exp_unf(4'h0, fault)}, {4'h0, valid});
        end
        @(negedge CLK_IN);
        RST_IN = 1'b1;
        repeat (2) @(negedge CLK_IN);
        RST_IN = 1'b0;
        chk("mid reset", 8'h00, {rx_off, valid});
        rd(rpv_pkg::ADDR_RX_POWER_DOWN, 8'h00);
        give_verdict();
    end
endmodule : rpv_ref_input_ctrl_tb
`default_nettype wire
